// ===== pkg/seep_pkg.sv
// constants and types for the three-wire serial nonvolatile memory
package seep_pkg;

    localparam int CLK_PERIOD_NS = 20;
    localparam int PROG_TIME_NS  = 5000000;
    // longest time: integer division rounds down
    localparam int PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int TIMER_W       = 18;
    localparam int MEM_BYTES     = 512;

    localparam logic [4:0] CMD_LEN_X8   = 5'h0b;
    localparam logic [4:0] CMD_LEN_X16  = 5'h0a;
    localparam logic [4:0] WORD_LEN_X8  = 5'h08;
    localparam logic [4:0] WORD_LEN_X16 = 5'h10;

    localparam logic [1:0] OPC_EXT   = 2'h0;
    localparam logic [1:0] OPC_WRITE = 2'h1;
    localparam logic [1:0] OPC_READ  = 2'h2;
    localparam logic [1:0] OPC_ERASE = 2'h3;
    localparam logic [1:0] EXT_LOCK   = 2'h0;
    localparam logic [1:0] EXT_FILL   = 2'h1;
    localparam logic [1:0] EXT_CLEAR  = 2'h2;
    localparam logic [1:0] EXT_UNLOCK = 2'h3;

    localparam logic [8:0] LAST_BYTE_LARGE = 9'h1ff;
    localparam logic [8:0] LAST_BYTE_SMALL = 9'h0ff;
    localparam logic [8:0] WADDR_X8_LARGE  = 9'h1ff;
    localparam logic [8:0] WADDR_X8_SMALL  = 9'h0ff;
    localparam logic [8:0] WADDR_X16_LARGE = 9'h0ff;
    localparam logic [8:0] WADDR_X16_SMALL = 9'h07f;
    localparam logic [7:0] ERASED_BYTE     = 8'hff;

    localparam logic       PROG_EN_RST = 1'b0;
    localparam logic [4:0] SYNC_RST    = 5'h00;
    localparam logic [4:0] CNT_RST     = 5'h00;

    typedef enum logic [1:0] {
        PRG_WORD  = 2'h0,
        PRG_ERASE = 2'h1,
        PRG_FILL  = 2'h2,
        PRG_CLEAR = 2'h3
    } seep_prg_op_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_CMD  = 5'h02,
        ST_DATA = 5'h04,
        ST_READ = 5'h08,
        ST_DONE = 5'h10
    } seep_state_t;

    typedef enum logic [1:0] {
        CORE_IDLE = 2'h1,
        CORE_BUSY = 2'h2
    } seep_core_state_t;

endpackage

// ===== pkg/seep_nvm_if.sv
// link between the serial front end and the storage core
`timescale 1ns/100ps
interface seep_nvm_if;
    import seep_pkg::*;
    logic         req;
    seep_prg_op_t op;
    logic [8:0]   addr;
    logic [15:0]  wdata;
    logic         x16;
    logic         dens_small;
    logic         busy;
    logic [8:0]   rd_addr;
    logic [15:0]  rd_data;

    modport ctrl (output req, op, addr, wdata, x16, dens_small, rd_addr,
                  input  busy, rd_data);
    modport core (input  req, op, addr, wdata, x16, dens_small, rd_addr,
                  output busy, rd_data);
endinterface

// ===== hdl/seep_nvm_core.sv
// storage array with self-timed programming sequencer
`timescale 1ns/100ps
module seep_nvm_core
    import seep_pkg::*;
#(
    parameter int PROG_CYCLES_P = PROG_CYCLES
)
(
    // clock and reset
    input  wire logic  clk_i,
    input  wire logic  rst_n_i,
    // front end
    seep_nvm_if.core   nvm
);

    logic [7:0]       mem [MEM_BYTES];
    seep_core_state_t state_reg,  state_next;
    logic [TIMER_W-1:0] timer_reg, timer_next;
    logic [8:0]       idx_reg,    idx_next;
    logic [8:0]       last_reg,   last_next;
    logic             sweep_reg,  sweep_next;
    logic             x16_reg,    x16_next;
    seep_prg_op_t     op_reg,     op_next;
    logic [15:0]      data_reg,   data_next;
    logic             mem_we;
    logic [7:0]       mem_wd;
    logic [8:0]       top_mask;
    logic [8:0]       ra;

    always_comb
    begin
        state_next = state_reg;
        timer_next = timer_reg;
        idx_next   = idx_reg;
        last_next  = last_reg;
        sweep_next = sweep_reg;
        x16_next   = x16_reg;
        op_next    = op_reg;
        data_next  = data_reg;
        mem_we     = 1'b0;
        mem_wd     = ERASED_BYTE;
        top_mask   = nvm.dens_small ? LAST_BYTE_SMALL : LAST_BYTE_LARGE;
        case (state_reg)
            CORE_IDLE:
            begin
                if (nvm.req)
                begin
                    state_next = CORE_BUSY;
                    // self-timed from here, no host clocks needed
                    timer_next = TIMER_W'(PROG_CYCLES_P - 1);
                    sweep_next = 1'b1;
                    x16_next   = nvm.x16;
                    op_next    = nvm.op;
                    data_next  = nvm.wdata;
                    if (nvm.op == PRG_FILL || nvm.op == PRG_CLEAR)
                    begin
                        idx_next  = 9'h000;
                        last_next = top_mask;
                    end
                    else if (nvm.x16)
                    begin
                        idx_next  = {nvm.addr[7:0], 1'b0} & top_mask;
                        last_next = {nvm.addr[7:0], 1'b1} & top_mask;
                    end
                    else
                    begin
                        idx_next  = nvm.addr & top_mask;
                        last_next = nvm.addr & top_mask;
                    end
                end
            end
            CORE_BUSY:
            begin
                if (sweep_reg)
                begin
                    mem_we = 1'b1;
                    // plain overwrite, erase only for erase ops
                    if (op_reg == PRG_WORD || op_reg == PRG_FILL)
                        mem_wd = (x16_reg && idx_reg[0]) ? data_reg[15:8]
                                                         : data_reg[7:0];
                    if (idx_reg == last_reg)
                        sweep_next = 1'b0;
                    else
                        idx_next = idx_reg + 9'h001;
                end
                if (timer_reg != '0)
                    timer_next = timer_reg - 1'b1;
                else if (!sweep_reg)
                    state_next = CORE_IDLE;
            end
            default:
                state_next = CORE_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_reg <= CORE_IDLE;
            timer_reg <= '0;
            idx_reg   <= 9'h000;
            last_reg  <= 9'h000;
            sweep_reg <= 1'b0;
            x16_reg   <= 1'b1;
            op_reg    <= PRG_WORD;
            data_reg  <= 16'h0000;
        end
        else
        begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            idx_reg   <= idx_next;
            last_reg  <= last_next;
            sweep_reg <= sweep_next;
            x16_reg   <= x16_next;
            op_reg    <= op_next;
            data_reg  <= data_next;
        end
    end

    // array content is not reset, like real cells
    always_ff @(posedge clk_i)
    begin
        if (mem_we)
            mem[idx_reg] <= mem_wd;
    end

    assign nvm.busy = (state_reg == CORE_BUSY);
    assign ra = (nvm.x16 ? {nvm.rd_addr[7:0], 1'b0} : nvm.rd_addr) & top_mask;
    assign nvm.rd_data = nvm.x16 ? {mem[{ra[8:1], 1'b1}], mem[ra]}
                                 : {8'h00, mem[ra]};

endmodule

// ===== hdl/seep_top.sv
// serial front end of the three-wire nonvolatile memory
`timescale 1ns/100ps
module seep_top
    import seep_pkg::*;
#(
    parameter int   PROG_CYCLES_P   = PROG_CYCLES,
    parameter logic SMALL_DENSITY_P = 1'b0
)
(
    // clock and reset
    input  wire logic CLK_SYS_I,
    input  wire logic ARST_N_I,
    // serial link
    input  wire logic CHIP_SELECT_I,
    input  wire logic SHIFT_CLOCK_I,
    input  wire logic SERIAL_IN_I,
    output logic      SERIAL_OUT_O,
    output logic      SERIAL_OUT_OE_O,
    // organization strap
    input  wire logic WORD_WIDTH_STRAP_I,
    input  wire logic STRAP_CONNECTED_I
);

    seep_nvm_if nvm ();

    seep_nvm_core #(
        .PROG_CYCLES_P (PROG_CYCLES_P)
    ) u_core (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (ARST_N_I),
        .nvm     (nvm.core)
    );

    logic [4:0]   sync1_reg;
    logic [4:0]   sync2_reg;
    logic         sk_prev_reg;
    logic         cs_s, sk_s, di_s, x16, sk_rise;

    seep_state_t  state_reg,   state_next;
    logic [4:0]   cnt_reg,     cnt_next;
    logic [10:0]  cmd_reg,     cmd_next;
    logic [15:0]  wdata_reg,   wdata_next;
    logic [15:0]  rd_sh_reg,   rd_sh_next;
    logic [8:0]   rd_addr_reg, rd_addr_next;
    logic [8:0]   prg_addr_reg, prg_addr_next;
    seep_prg_op_t op_reg,      op_next;
    logic         req_reg,     req_next;
    logic         prog_en_reg, prog_en_next;
    logic         status_reg,  status_next;
    logic         do_reg,      do_next;
    logic         oe_reg,      oe_next;

    logic [10:0]  new_cmd;
    logic [15:0]  new_data;
    logic [1:0]   opc, ext;
    logic [8:0]   cmd_addr, addr_mask;
    logic [4:0]   cmd_len, word_len;
    logic [15:0]  rd_word;

    // first stage feeds only the second
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            sync1_reg   <= SYNC_RST;
            sync2_reg   <= SYNC_RST;
            sk_prev_reg <= 1'b0;
        end
        else
        begin
            sync1_reg   <= {CHIP_SELECT_I, SHIFT_CLOCK_I, SERIAL_IN_I,
                            WORD_WIDTH_STRAP_I, STRAP_CONNECTED_I};
            sync2_reg   <= sync1_reg;
            sk_prev_reg <= sync2_reg[3];
        end
    end

    assign cs_s    = sync2_reg[4];
    assign sk_s    = sync2_reg[3];
    assign di_s    = sync2_reg[2];
    assign sk_rise = sk_s & ~sk_prev_reg;
    // open strap counts as high
    assign x16     = sync2_reg[1] | ~sync2_reg[0];

    assign cmd_len  = x16 ? CMD_LEN_X16 : CMD_LEN_X8;
    assign word_len = x16 ? WORD_LEN_X16 : WORD_LEN_X8;
    assign new_cmd  = {cmd_reg[9:0], di_s};
    assign new_data = {wdata_reg[14:0], di_s};
    assign opc      = x16 ? new_cmd[9:8] : new_cmd[10:9];
    assign ext      = x16 ? new_cmd[7:6] : new_cmd[8:7];
    assign cmd_addr = x16 ? {1'b0, new_cmd[7:0]} : new_cmd[8:0];
    assign addr_mask = x16 ? (SMALL_DENSITY_P ? WADDR_X16_SMALL
                                              : WADDR_X16_LARGE)
                           : (SMALL_DENSITY_P ? WADDR_X8_SMALL
                                              : WADDR_X8_LARGE);
    // bytes ride in the upper lane so msb first works for both widths
    assign rd_word  = x16 ? nvm.rd_data : {nvm.rd_data[7:0], 8'h00};

    always_comb
    begin
        state_next    = state_reg;
        cnt_next      = cnt_reg;
        cmd_next      = cmd_reg;
        wdata_next    = wdata_reg;
        rd_sh_next    = rd_sh_reg;
        rd_addr_next  = rd_addr_reg;
        prg_addr_next = prg_addr_reg;
        op_next       = op_reg;
        req_next      = 1'b0;
        prog_en_next  = prog_en_reg;
        status_next   = status_reg;
        do_next       = do_reg;
        oe_next       = 1'b0;
        if (!cs_s)
        begin
            // abort and float on deselect
            state_next = ST_IDLE;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (status_reg)
                    begin
                        // low while busy, high when done
                        oe_next = 1'b1;
                        do_next = ~nvm.busy;
                    end
                    if (sk_rise && di_s)
                    begin
                        state_next  = ST_CMD;
                        cnt_next    = CNT_RST;
                        cmd_next    = 11'h000;
                        status_next = 1'b0;
                        oe_next     = 1'b0;
                    end
                end
                ST_CMD:
                begin
                    if (sk_rise)
                    begin
                        cmd_next = new_cmd;
                        cnt_next = cnt_reg + 5'h01;
                        // full field length always shifted
                        if (cnt_reg + 5'h01 == cmd_len)
                        begin
                            prg_addr_next = cmd_addr;
                            cnt_next      = CNT_RST;
                            state_next    = ST_DONE;
                            if (opc == OPC_READ)
                            begin
                                // dummy zero precedes data
                                state_next   = ST_READ;
                                rd_addr_next = cmd_addr & addr_mask;
                                do_next      = 1'b0;
                                oe_next      = 1'b1;
                            end
                            else if (opc == OPC_WRITE)
                            begin
                                state_next = ST_DATA;
                                op_next    = PRG_WORD;
                            end
                            else if (opc == OPC_ERASE)
                            begin
                                op_next     = PRG_ERASE;
                                req_next    = prog_en_reg && !nvm.busy;
                                status_next = prog_en_reg && !nvm.busy;
                            end
                            else if (ext == EXT_UNLOCK)
                                prog_en_next = 1'b1;
                            else if (ext == EXT_LOCK)
                                prog_en_next = 1'b0;
                            else if (ext == EXT_CLEAR)
                            begin
                                op_next     = PRG_CLEAR;
                                req_next    = prog_en_reg && !nvm.busy;
                                status_next = prog_en_reg && !nvm.busy;
                            end
                            else
                            begin
                                state_next = ST_DATA;
                                op_next    = PRG_FILL;
                            end
                        end
                    end
                end
                ST_DATA:
                begin
                    if (sk_rise)
                    begin
                        wdata_next = new_data;
                        cnt_next   = cnt_reg + 5'h01;
                        if (cnt_reg + 5'h01 == word_len)
                        begin
                            state_next = ST_DONE;
                            // locked or busy: dropped silently
                            req_next    = prog_en_reg && !nvm.busy;
                            status_next = prog_en_reg && !nvm.busy;
                            if (!x16)
                                wdata_next = {8'h00, new_data[7:0]};
                        end
                    end
                end
                ST_READ:
                begin
                    oe_next = 1'b1;
                    if (sk_rise)
                    begin
                        if (cnt_reg == CNT_RST)
                        begin
                            // next word follows without a new command
                            do_next      = rd_word[15];
                            rd_sh_next   = {rd_word[14:0], 1'b0};
                            cnt_next     = word_len - 5'h01;
                            rd_addr_next = (rd_addr_reg + 9'h001) & addr_mask;
                        end
                        else
                        begin
                            do_next    = rd_sh_reg[15];
                            rd_sh_next = {rd_sh_reg[14:0], 1'b0};
                            cnt_next   = cnt_reg - 5'h01;
                        end
                    end
                end
                ST_DONE:
                    state_next = ST_DONE;
                default:
                    state_next = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            state_reg    <= ST_IDLE;
            cnt_reg      <= CNT_RST;
            cmd_reg      <= 11'h000;
            wdata_reg    <= 16'h0000;
            rd_sh_reg    <= 16'h0000;
            rd_addr_reg  <= 9'h000;
            prg_addr_reg <= 9'h000;
            op_reg       <= PRG_WORD;
            req_reg      <= 1'b0;
            prog_en_reg  <= PROG_EN_RST;
            status_reg   <= 1'b0;
            do_reg       <= 1'b0;
            oe_reg       <= 1'b0;
        end
        else
        begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            cmd_reg      <= cmd_next;
            wdata_reg    <= wdata_next;
            rd_sh_reg    <= rd_sh_next;
            rd_addr_reg  <= rd_addr_next;
            prg_addr_reg <= prg_addr_next;
            op_reg       <= op_next;
            req_reg      <= req_next;
            prog_en_reg  <= prog_en_next;
            status_reg   <= status_next;
            do_reg       <= do_next;
            oe_reg       <= oe_next;
        end
    end

    assign nvm.req     = req_reg;
    assign nvm.op      = op_reg;
    assign nvm.addr    = prg_addr_reg;
    assign nvm.wdata   = wdata_reg;
    assign nvm.x16     = x16;
    assign nvm.dens_small = SMALL_DENSITY_P;
    assign nvm.rd_addr = rd_addr_reg;

    assign SERIAL_OUT_O    = do_reg;
    assign SERIAL_OUT_OE_O = oe_reg;

endmodule

// ===== tb/seep_properties.sv
// assertion checker for the serial memory front end, bound to its top
`timescale 1ns/100ps
module seep_properties
    import seep_pkg::*;
#(
    parameter int PROG_CYCLES_P = PROG_CYCLES
)
(
    // clock and reset
    input  wire logic CLK_SYS_I,
    input  wire logic ARST_N_I,
    // serial link and strap
    input  wire logic CHIP_SELECT_I,
    input  wire logic SHIFT_CLOCK_I,
    input  wire logic SERIAL_IN_I,
    input  wire logic SERIAL_OUT_O,
    input  wire logic SERIAL_OUT_OE_O,
    input  wire logic WORD_WIDTH_STRAP_I,
    input  wire logic STRAP_CONNECTED_I
);
    logic        sk_reg;
    logic [3:0]  since_reg;
    logic [4:0]  rises_reg;
    logic [19:0] low_reg;

    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!ARST_N_I);

    // pin-level trackers; the design sees these edges some clocks later
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            sk_reg    <= 1'b0;
            since_reg <= 4'hf;
            rises_reg <= 5'h00;
            low_reg   <= 20'h00000;
        end
        else
        begin
            sk_reg    <= SHIFT_CLOCK_I;
            since_reg <= (SHIFT_CLOCK_I && !sk_reg) ? 4'h0 :
                         (since_reg == 4'hf) ? since_reg : since_reg + 4'h1;
            rises_reg <= !CHIP_SELECT_I ? 5'h00 :
                         (SHIFT_CLOCK_I && !sk_reg && rises_reg != 5'h1f) ?
                         rises_reg + 5'h01 : rises_reg;
            low_reg   <= (SERIAL_OUT_OE_O && !SERIAL_OUT_O) ?
                         low_reg + 20'h00001 : 20'h00000;
        end
    end

    sequence s_deselected;
        !CHIP_SELECT_I [*6];
    endsequence

    // status or read data held while nothing on the link moves
    sequence s_quiet_drive;
        (SERIAL_OUT_OE_O && CHIP_SELECT_I && !SHIFT_CLOCK_I) [*8];
    endsequence

    AST_RESET_QUIET: assert property (
        $rose(ARST_N_I) |-> !SERIAL_OUT_OE_O && !SERIAL_OUT_O)
        else $error("output active right after reset");
    AST_DESELECT_RELEASE: assert property (
        $fell(CHIP_SELECT_I) |-> ##[1:6] !SERIAL_OUT_OE_O)
        else $error("output not released after deselect");
    AST_DESELECT_STAYS: assert property (
        s_deselected |-> !SERIAL_OUT_OE_O)
        else $error("output driven while deselected");
    AST_DRIVE_NEEDS_SELECT: assert property (
        $rose(SERIAL_OUT_OE_O) |-> $past(CHIP_SELECT_I, 2))
        else $error("output enabled without select");
    AST_BUSY_BOUNDED: assert property (
        low_reg <= PROG_CYCLES_P + 8)
        else $error("busy status held too long");
    AST_READ_PACED: assert property (
        SERIAL_OUT_OE_O && $past(SERIAL_OUT_OE_O) && $fell(SERIAL_OUT_O)
        |-> since_reg >= 4'h1 && since_reg <= 4'h7)
        else $error("data bit changed without a shift clock");
    AST_DRIVE_HOLDS: assert property (
        s_quiet_drive |=> SERIAL_OUT_OE_O)
        else $error("output dropped while selected and idle");
    AST_READ_AFTER_COMMAND: assert property (
        $rose(SERIAL_OUT_OE_O) |-> rises_reg == 5'h00 || rises_reg >= 5'h0b)
        else $error("read data before a complete command");
endmodule

bind seep_top seep_properties #(.PROG_CYCLES_P(PROG_CYCLES_P)) prop_u (
    .CLK_SYS_I(CLK_SYS_I), .ARST_N_I(ARST_N_I),
    .CHIP_SELECT_I(CHIP_SELECT_I), .SHIFT_CLOCK_I(SHIFT_CLOCK_I),
    .SERIAL_IN_I(SERIAL_IN_I), .SERIAL_OUT_O(SERIAL_OUT_O),
    .SERIAL_OUT_OE_O(SERIAL_OUT_OE_O),
    .WORD_WIDTH_STRAP_I(WORD_WIDTH_STRAP_I),
    .STRAP_CONNECTED_I(STRAP_CONNECTED_I)
);

// ===== tb/seep_host.sv
// host serial master model: select, shift clock and data in
`timescale 1ns/100ps
module seep_host
(
    // clock and returned data
    input  wire logic clk_i,
    input  wire logic serial_i,
    // link outputs
    output logic      cs_o,
    output logic      sk_o,
    output logic      di_o
);
    initial
    begin
        cs_o = 1'b0;
        sk_o = 1'b0;
        di_o = 1'b0;
    end

    task automatic open_frame();
        cs_o <= 1'b1;
        repeat (8) @(posedge clk_i);
    endtask

    // clock stays low between frames; data flipped so no stale bit lingers
    task automatic close_frame();
        cs_o <= 1'b0;
        di_o <= ~di_o;
        repeat (8) @(posedge clk_i);
    endtask

    // msb first; don't-care bits are clocked too, full field length
    task automatic shift(input logic [31:0] bits, input int n,
                         output logic [31:0] got);
        got = '0;
        for (int i = n - 1; i >= 0; i--)
        begin
            // 8 clocks a bit: data leads the rise by 3, high 4, low 4
            di_o <= bits[i];
            repeat (3) @(posedge clk_i);
            sk_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            sk_o <= 1'b0;
            repeat (1) @(posedge clk_i);
            got = {got[30:0], serial_i};
        end
    endtask
endmodule

// ===== tb/testbench.sv
// self-checking bench for the three-wire serial memory
`timescale 1ns/100ps
module testbench;
    import seep_pkg::*;
    localparam int PROG_P = 600;
    localparam int LIMIT  = 40000;
    typedef struct packed {logic x16; logic [8:0] a; logic [15:0] d;
                           logic [15:0] q;} seep_row_t;
    logic        clk;
    logic        arst_n;
    logic        strap;
    logic        conn;
    logic        dout;
    logic        doe;
    logic        cs;
    logic        sk;
    logic        di;
    wire         do_w;
    int          miscompares;
    int          comparisons;
    int          cycles;
    int          n;
    logic [31:0] r;
    seep_row_t   rows [4] = '{'{1'b1, 9'h005, 16'ha5c3, 16'ha5c3},
        '{1'b1, 9'h0ff, 16'h1234, 16'h1234},
        '{1'b0, 9'h1ff, 16'h007e, 16'h007e},
        '{1'b0, 9'h000, 16'h0081, 16'h0081}};

    assign do_w = doe ? dout : 1'bz;

    seep_top #(.PROG_CYCLES_P(PROG_P), .SMALL_DENSITY_P(1'b0)) dut_u (
        .CLK_SYS_I(clk), .ARST_N_I(arst_n), .CHIP_SELECT_I(cs),
        .SHIFT_CLOCK_I(sk), .SERIAL_IN_I(di), .SERIAL_OUT_O(dout),
        .SERIAL_OUT_OE_O(doe), .WORD_WIDTH_STRAP_I(strap),
        .STRAP_CONNECTED_I(conn));
    seep_host host_u (.clk_i(clk), .serial_i(do_w), .cs_o(cs), .sk_o(sk),
        .di_o(di));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic stop_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            miscompares++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic word_width_strap(input logic s, input logic c);
        strap <= s;
        conn  <= c;
        repeat (4) @(posedge clk);
    endtask

    // one whole frame; the last field's returned bits land in r
    task automatic cmd(input logic [1:0] op, input logic [8:0] a,
                       input logic [31:0] d, input int dn);
        logic [31:0] g;
        host_u.open_frame();
        host_u.shift({29'h0, 1'b1, op}, 3, g);
        host_u.shift({23'h0, a}, (strap || !conn) ? 8 : 9, g);
        if (dn > 0)
            host_u.shift(d, dn, g);
        r = g;
        host_u.close_frame();
    endtask

    task automatic ext(input logic [1:0] e, input logic [15:0] d, input int dn);
        cmd(OPC_EXT, (strap || !conn) ? {1'b0, e, 6'h00} : {e, 7'h00},
            {16'h0, d}, dn);
    endtask

    // busy must show on reselect, then ready inside the programming bound
    task automatic prog_wait();
        host_u.open_frame();
        chk(do_w, 1'b0);
        n = 0;
        while (do_w !== 1'b1 && n < 2000)
        begin
            @(posedge clk);
            n++;
        end
        chk(n > 500 && n <= PROG_P, 1'b1);
        host_u.close_frame();
    endtask

    initial
    begin
        arst_n = 1'b0;
        strap = 1'b1;
        conn = 1'b1;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk(doe, 1'b0);
        ext(EXT_UNLOCK, 16'h0, 0);
        ext(EXT_FILL, 16'h5aa5, 16);
        prog_wait();
        cmd(OPC_READ, 9'h040, 32'h0, 32);
        chk(r, 32'h5aa55aa5);
        $display("test fill done");
        // writes land on filled words with no erase in between
        foreach (rows[i])
        begin
            word_width_strap(rows[i].x16, 1'b1);
            cmd(OPC_WRITE, rows[i].a, {16'h0, rows[i].d},
                rows[i].x16 ? 16 : 8);
            prog_wait();
            cmd(OPC_READ, rows[i].a, 32'h0, rows[i].x16 ? 16 : 8);
            chk(r, {16'h0, rows[i].q});
            $display("test row %0d done", i);
        end
        cmd(OPC_READ, 9'h00a, 32'h0, 16);
        chk(r, 32'hc3a5);
        cmd(OPC_READ, 9'h1ff, 32'h0, 16);
        chk(r, 32'h7e81);
        word_width_strap(1'b1, 1'b1);
        cmd(OPC_READ, 9'h0ff, 32'h0, 32);
        chk(r, 32'h7e345a81);
        word_width_strap(1'b0, 1'b0);
        cmd(OPC_READ, 9'h005, 32'h0, 16);
        chk(r, 32'ha5c3);
        $display("test organization done");
        word_width_strap(1'b1, 1'b1);
        cmd(OPC_ERASE, 9'h005, 32'h0, 0);
        prog_wait();
        // write cut short by deselect must leave the word alone
        host_u.open_frame();
        host_u.shift({29'h0, 1'b1, OPC_WRITE}, 3, r);
        host_u.shift(32'h5, 8, r);
        host_u.shift(32'h0, 4, r);
        host_u.close_frame();
        host_u.open_frame();
        chk(doe, 1'b0);
        host_u.close_frame();
        cmd(OPC_READ, 9'h005, 32'h0, 16);
        chk(r, 32'hffff);
        $display("test erase and abort done");
        ext(EXT_LOCK, 16'h0, 0);
        cmd(OPC_WRITE, 9'h005, 32'h1111, 16);
        host_u.open_frame();
        chk(doe, 1'b0);
        host_u.close_frame();
        cmd(OPC_READ, 9'h005, 32'h0, 16);
        chk(r, 32'hffff);
        ext(EXT_UNLOCK, 16'h0, 0);
        ext(EXT_CLEAR, 16'h0, 0);
        prog_wait();
        cmd(OPC_READ, 9'h000, 32'h0, 32);
        chk(r, 32'hffffffff);
        $display("test lock and clear done");
        // a reset in mid-run must lock programming again
        ext(EXT_UNLOCK, 16'h0, 0);
        arst_n <= 1'b0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk(doe, 1'b0);
        cmd(OPC_WRITE, 9'h005, 32'h2222, 16);
        host_u.open_frame();
        chk(doe, 1'b0);
        host_u.close_frame();
        cmd(OPC_READ, 9'h005, 32'h0, 16);
        chk(r, 32'hffff);
        $display("test reset done");
        stop_test();
    end
endmodule
